// ---- logic/sfw_pkg.sv ----
package sfw_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS       = 50;
	localparam int WR_DELAY_US  = 10;
	localparam int PROG_US      = 20;
	localparam int ERASE_US     = 40;
	localparam int STWR_US      = 10;
	// least times, so round up to whole cycles
	localparam int WR_DELAY_CYC = (WR_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int PROG_CYC     = (PROG_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int ERASE_CYC    = (ERASE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int STWR_CYC     = (STWR_US * 1000 + CLK_NS - 1) / CLK_NS;

	// ------------------------------------------------------------
	// instruction codes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_WREN  = 8'h06;
	localparam logic [7:0] OP_WRDI  = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_RDSR3 = 8'h15;
	localparam logic [7:0] OP_WRSR1 = 8'h01;
	localparam logic [7:0] OP_WRSR2 = 8'h31;
	localparam logic [7:0] OP_WRSR3 = 8'h11;
	localparam logic [7:0] OP_PP    = 8'h02;
	localparam logic [7:0] OP_SE    = 8'h20;
	localparam logic [7:0] OP_BE    = 8'hd8;
	localparam logic [7:0] OP_CE    = 8'hc7;
	localparam logic [7:0] OP_PD    = 8'hb9;
	localparam logic [7:0] OP_RPD   = 8'hab;
	localparam logic [7:0] OP_UNLK  = 8'h39;
	localparam logic [7:0] OP_PFX1  = 8'haa;
	localparam logic [7:0] OP_PFX2  = 8'h55;

	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam logic [3:0] LEN_ADDR = 4'h5;
	localparam logic [3:0] LEN_PROG = 4'h6;
	localparam logic [3:0] LEN_STWR = 4'h2;
	localparam logic [3:0] LEN_STW2 = 4'h3;

	// ------------------------------------------------------------
	// status field positions
	// ------------------------------------------------------------
	localparam int POS_BUSY   = 0;
	localparam int POS_LATCH  = 1;
	localparam int POS_BLKPR  = 2;
	localparam int POS_TOPBOT = 6;
	localparam int POS_STPROT = 7;
	localparam int POS_STLOCK = 0;
	localparam int POS_QUAD   = 1;
	localparam int POS_COMPL  = 6;
	localparam int POS_SCHEME = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0] BLKPR_RST  = 4'h0;
	localparam logic       TOPBOT_RST = 1'b0;
	localparam logic       COMPL_RST  = 1'b0;
	localparam logic       STPROT_RST = 1'b0;
	localparam logic       STLOCK_RST = 1'b0;
	localparam logic       QUAD_RST   = 1'b0;
	localparam logic       SCHEME_RST = 1'b0;

	// ------------------------------------------------------------
	// array geometry
	// ------------------------------------------------------------
	localparam int NUM_LOCKS = 542;
	localparam logic [8:0] BLK_TOP  = 9'h1ff;
	localparam logic [9:0] BLK_ALL  = 10'h200;
	localparam logic [9:0] MID_BASE = 10'h01f;

endpackage

// ---- logic/sfw_sync.sv ----
`timescale 1ns/100ps
module sfw_sync #(
	parameter int             W    = 4,
	parameter logic [W-1:0]   INIT = '0
)(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// raw and synchronised levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= INIT;
			q        <= INIT;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule

// ---- logic/sfw_top.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// write protection and status logic
// ------------------------------------------------------------
module sfw_top #(
	parameter int WR_DELAY_CYC = sfw_pkg::WR_DELAY_CYC,
	parameter int PROG_CYC     = sfw_pkg::PROG_CYC,
	parameter int ERASE_CYC    = sfw_pkg::ERASE_CYC,
	parameter int STWR_CYC     = sfw_pkg::STWR_CYC
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// serial link
	input  wire logic        spi_sclk,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_mosi,
	output logic             spi_miso,
	output logic             spi_miso_oe,
	// write protect pin
	input  wire logic        wp_n,
	// array operation request
	output logic             array_go,
	output logic [7:0]       array_op,
	output logic [24:0]      array_addr,
	// status view
	output logic [7:0]       status_byte_one,
	output logic [7:0]       status_byte_two
);

	typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_PDOWN} sfw_state_t;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic range_prot(
		input logic [3:0] bp,
		input logic       tb,
		input logic       cmp,
		input logic [8:0] blk
	);
		logic [9:0] n;
		logic       hit;
		n   = 10'h000;
		hit = 1'b0;
		if (bp >= 4'ha)
			n = sfw_pkg::BLK_ALL;
		else if (bp != 4'h0)
			n = 10'(10'h001 << (bp - 4'h1));
		if (tb)
			hit = {1'b0, blk} < n;
		else
			hit = {1'b0, blk} >= (sfw_pkg::BLK_ALL - n);
		return hit ^ cmp;
	endfunction

	function automatic logic [9:0] lock_idx(input logic [24:0] a);
		// end blocks lock per sector, middle blocks per block
		if (a[24:16] == 9'h000)
			return {6'h00, a[15:12]};
		else if (a[24:16] == sfw_pkg::BLK_TOP)
			return {6'h01, a[15:12]};
		else
			return 10'(sfw_pkg::MID_BASE + {1'b0, a[24:16]});
	endfunction

	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	logic [3:0] pin_s;
	logic       sclk_q_reg;
	logic       cs_q_reg;

	sfw_sync #(.W(4), .INIT(4'ha)) u_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.d    ({wp_n, spi_mosi, spi_cs_n, spi_sclk}),
		.q    (pin_s)
	);

	wire sclk_s = pin_s[0];
	wire cs_s   = pin_s[1];
	wire mosi_s = pin_s[2];
	wire wp_s   = pin_s[3];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_q_reg <= 1'b0;
			cs_q_reg   <= 1'b1;
		end else begin
			sclk_q_reg <= sclk_s;
			cs_q_reg   <= cs_s;
		end
	end

	wire sclk_rise = sclk_s & ~sclk_q_reg & ~cs_s;
	wire sclk_fall = ~sclk_s & sclk_q_reg & ~cs_s;
	wire cs_fall   = ~cs_s & cs_q_reg;
	wire cs_rise   = cs_s & ~cs_q_reg;

	// ------------------------------------------------------------
	// frame capture
	// ------------------------------------------------------------
	logic [2:0]  bit_cnt_reg;
	logic [3:0]  byte_cnt_reg;
	logic [7:0]  sh_reg;
	logic [7:0]  op_reg;
	logic [7:0]  dat1_reg;
	logic [7:0]  dat2_reg;
	logic [31:0] addr_reg;

	wire [7:0] sh_next   = {sh_reg[6:0], mosi_s};
	wire       byte_done = sclk_rise & (bit_cnt_reg == 3'h7);

	always_ff @(posedge clk) begin
		if (!rst_n || cs_fall) begin
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 4'h0;
		end else if (sclk_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (byte_done && byte_cnt_reg != 4'hf)
				byte_cnt_reg <= byte_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sh_reg   <= 8'h00;
			op_reg   <= 8'h00;
			dat1_reg <= 8'h00;
			dat2_reg <= 8'h00;
			addr_reg <= 32'h0000_0000;
		end else if (sclk_rise) begin
			sh_reg <= sh_next;
			if (byte_done && byte_cnt_reg == 4'h0)
				op_reg <= sh_next;
			if (byte_done && byte_cnt_reg == 4'h1)
				dat1_reg <= sh_next;
			if (byte_done && byte_cnt_reg == 4'h2)
				dat2_reg <= sh_next;
			if (byte_done && byte_cnt_reg != 4'h0
					&& byte_cnt_reg < sfw_pkg::LEN_ADDR)
				addr_reg <= {addr_reg[23:0], sh_next};
		end
	end

	// ------------------------------------------------------------
	// state and status bits
	// ------------------------------------------------------------
	sfw_state_t state_reg;
	sfw_state_t state_next;
	logic [15:0] busy_cnt_reg;
	logic [15:0] delay_cnt_reg;
	logic [1:0]  arm_reg;
	logic        otp_reg;
	logic        write_enable_latch_reg;
	logic [3:0]  block_protect_bits_reg;
	logic        top_bottom_select_reg;
	logic        complement_protect_reg;
	logic        status_protect_bit_reg;
	logic        status_lock_bit_reg;
	logic        quad_enable_bit_reg;
	logic        protect_scheme_select_reg;
	logic [sfw_pkg::NUM_LOCKS-1:0] lock_reg;

	wire in_busy  = state_reg == ST_BUSY;
	wire in_pd    = state_reg == ST_PDOWN;
	wire wr_ready = delay_cnt_reg == 16'h0000;
	wire frame_ok = cs_rise & (bit_cnt_reg == 3'h0)
		& (byte_cnt_reg != 4'h0);
	wire can_cmd  = frame_ok & ~in_busy & ~in_pd;
	wire can_wr   = can_cmd & wr_ready;
	wire n_one    = byte_cnt_reg == 4'h1;

	wire op_stwr = (op_reg == sfw_pkg::OP_WRSR1)
		| (op_reg == sfw_pkg::OP_WRSR2) | (op_reg == sfw_pkg::OP_WRSR3);
	wire op_pe = (op_reg == sfw_pkg::OP_SE) | (op_reg == sfw_pkg::OP_BE);
	wire op_ce = op_reg == sfw_pkg::OP_CE;

	// pin is a data line in quad operation
	wire wp_low = ~wp_s & ~quad_enable_bit_reg;
	wire st_open = ~status_lock_bit_reg & ~otp_reg
		& ~(status_protect_bit_reg & wp_low);

	wire try_stwr = can_wr & op_stwr & (byte_cnt_reg >= sfw_pkg::LEN_STWR);
	wire is_stwr  = try_stwr & write_enable_latch_reg & st_open;
	wire is_wren  = can_wr & (op_reg == sfw_pkg::OP_WREN) & n_one;
	wire is_wrdi  = can_cmd & (op_reg == sfw_pkg::OP_WRDI) & n_one;
	wire is_pd    = can_cmd & (op_reg == sfw_pkg::OP_PD) & n_one;
	wire is_rpd   = frame_ok & in_pd & (op_reg == sfw_pkg::OP_RPD);
	wire is_unlk  = can_cmd & (op_reg == sfw_pkg::OP_UNLK)
		& (byte_cnt_reg == sfw_pkg::LEN_ADDR);
	wire try_arr  = can_wr & write_enable_latch_reg & (
		((op_reg == sfw_pkg::OP_PP) & (byte_cnt_reg >= sfw_pkg::LEN_PROG))
		| (op_pe & (byte_cnt_reg == sfw_pkg::LEN_ADDR)) | (op_ce & n_one));

	wire [8:0] tgt_blk = addr_reg[24:16];
	wire prot_rng = op_ce
		? range_prot(block_protect_bits_reg, top_bottom_select_reg,
			complement_protect_reg, 9'h000)
			| range_prot(block_protect_bits_reg, top_bottom_select_reg,
			complement_protect_reg, sfw_pkg::BLK_TOP)
		: range_prot(block_protect_bits_reg, top_bottom_select_reg,
			complement_protect_reg, tgt_blk);
	wire prot_lk = op_ce ? |lock_reg
		: lock_reg[lock_idx(addr_reg[24:0])];
	wire tgt_prot = protect_scheme_select_reg ? prot_lk : prot_rng;
	wire arr_ok   = try_arr & ~tgt_prot;
	wire op_done  = in_busy & (busy_cnt_reg == 16'h0000);

	wire [15:0] busy_len = !arr_ok ? 16'(STWR_CYC - 1)
		: (op_reg == sfw_pkg::OP_PP) ? 16'(PROG_CYC - 1)
		: 16'(ERASE_CYC - 1);

	wire wr_one = is_stwr & (op_reg == sfw_pkg::OP_WRSR1);
	wire wr_two = is_stwr & ((op_reg == sfw_pkg::OP_WRSR2)
		| ((op_reg == sfw_pkg::OP_WRSR1)
		& (byte_cnt_reg >= sfw_pkg::LEN_STW2)));
	wire wr_thr = is_stwr & (op_reg == sfw_pkg::OP_WRSR3);
	wire [7:0] two_val = (op_reg == sfw_pkg::OP_WRSR2) ? dat1_reg : dat2_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (arr_ok || is_stwr)
					state_next = ST_BUSY;
				else if (is_pd)
					state_next = ST_PDOWN;
			end
			ST_BUSY: begin
				if (op_done)
					state_next = ST_IDLE;
			end
			ST_PDOWN: begin
				if (is_rpd)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg     <= ST_IDLE;
			busy_cnt_reg  <= 16'h0000;
			delay_cnt_reg <= 16'(WR_DELAY_CYC);
		end else begin
			state_reg <= state_next;
			if (arr_ok || is_stwr)
				busy_cnt_reg <= busy_len;
			else if (in_busy && !op_done)
				busy_cnt_reg <= busy_cnt_reg - 16'h0001;
			if (!wr_ready)
				delay_cnt_reg <= delay_cnt_reg - 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			write_enable_latch_reg <= 1'b0;
		else if (is_wren)
			write_enable_latch_reg <= 1'b1;
		else if (is_wrdi || op_done)
			write_enable_latch_reg <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			arm_reg <= 2'h0;
		else if (can_cmd && op_reg == sfw_pkg::OP_PFX1)
			arm_reg <= 2'h1;
		else if (can_cmd && op_reg == sfw_pkg::OP_PFX2 && arm_reg == 2'h1)
			arm_reg <= 2'h2;
		else if (can_cmd && op_reg != sfw_pkg::OP_WREN)
			arm_reg <= 2'h0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			block_protect_bits_reg    <= sfw_pkg::BLKPR_RST;
			top_bottom_select_reg     <= sfw_pkg::TOPBOT_RST;
			complement_protect_reg    <= sfw_pkg::COMPL_RST;
			status_protect_bit_reg    <= sfw_pkg::STPROT_RST;
			status_lock_bit_reg       <= sfw_pkg::STLOCK_RST;
			quad_enable_bit_reg       <= sfw_pkg::QUAD_RST;
			protect_scheme_select_reg <= sfw_pkg::SCHEME_RST;
			otp_reg                   <= 1'b0;
		end else begin
			if (wr_one) begin
				block_protect_bits_reg <= dat1_reg[sfw_pkg::POS_BLKPR +: 4];
				top_bottom_select_reg  <= dat1_reg[sfw_pkg::POS_TOPBOT];
				status_protect_bit_reg <= dat1_reg[sfw_pkg::POS_STPROT];
			end
			if (wr_two) begin
				complement_protect_reg <= two_val[sfw_pkg::POS_COMPL];
				quad_enable_bit_reg    <= two_val[sfw_pkg::POS_QUAD];
				status_lock_bit_reg    <= two_val[sfw_pkg::POS_STLOCK];
				if (arm_reg == 2'h2 && two_val[sfw_pkg::POS_STLOCK])
					otp_reg <= 1'b1;
			end
			if (wr_thr)
				protect_scheme_select_reg <= dat1_reg[sfw_pkg::POS_SCHEME];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			lock_reg <= '1;
		else if (is_unlk)
			lock_reg[lock_idx(addr_reg[24:0])] <= 1'b0;
	end

	// ------------------------------------------------------------
	// status read and outputs
	// ------------------------------------------------------------
	logic [7:0] sr1;
	logic [7:0] sr2;
	logic [7:0] sr3;
	logic [7:0] out_sh_reg;

	always_comb begin
		sr1 = 8'h00;
		sr2 = 8'h00;
		sr3 = 8'h00;
		sr1[sfw_pkg::POS_BUSY]      = in_busy;
		sr1[sfw_pkg::POS_LATCH]     = write_enable_latch_reg;
		sr1[sfw_pkg::POS_BLKPR +: 4] = block_protect_bits_reg;
		sr1[sfw_pkg::POS_TOPBOT]    = top_bottom_select_reg;
		sr1[sfw_pkg::POS_STPROT]    = status_protect_bit_reg;
		sr2[sfw_pkg::POS_STLOCK]    = status_lock_bit_reg;
		sr2[sfw_pkg::POS_QUAD]      = quad_enable_bit_reg;
		sr2[sfw_pkg::POS_COMPL]     = complement_protect_reg;
		sr3[sfw_pkg::POS_SCHEME]    = protect_scheme_select_reg;
	end

	wire rd_op = (op_reg == sfw_pkg::OP_RDSR1)
		| (op_reg == sfw_pkg::OP_RDSR2) | (op_reg == sfw_pkg::OP_RDSR3);
	// reads stay open while busy so the host can poll
	wire rd_active = ~cs_s & (byte_cnt_reg != 4'h0) & rd_op & ~in_pd;
	wire [7:0] rd_sel = (op_reg == sfw_pkg::OP_RDSR2) ? sr2
		: (op_reg == sfw_pkg::OP_RDSR3) ? sr3 : sr1;

	assign spi_miso_oe = rd_active;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			spi_miso   <= 1'b0;
			out_sh_reg <= 8'h00;
		end else if (sclk_fall && rd_active) begin
			if (bit_cnt_reg == 3'h0) begin
				spi_miso   <= rd_sel[7];
				out_sh_reg <= {rd_sel[6:0], 1'b0};
			end else begin
				spi_miso   <= out_sh_reg[7];
				out_sh_reg <= {out_sh_reg[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			array_go        <= 1'b0;
			array_op        <= 8'h00;
			array_addr      <= 25'h0;
			status_byte_one <= 8'h00;
			status_byte_two <= 8'h00;
		end else begin
			array_go        <= arr_ok;
			status_byte_one <= sr1;
			status_byte_two <= sr2;
			if (arr_ok) begin
				array_op   <= op_reg;
				array_addr <= addr_reg[24:0];
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	delay_gate_a: assert property (
		!wr_ready |-> !write_enable_latch_reg)
		else $error("latch set during write delay");
	latch_reset_a: assert property (
		$rose(rst_n) |-> !write_enable_latch_reg && state_reg == ST_IDLE)
		else $error("latch not clear after reset");
	need_latch_a: assert property (
		(state_reg == ST_IDLE && !write_enable_latch_reg) |=> !in_busy)
		else $error("busy started without latch");
	done_clear_a: assert property (
		op_done |=> !write_enable_latch_reg && state_reg == ST_IDLE)
		else $error("latch kept after completion");
	pd_hold_a: assert property (
		(in_pd && !is_rpd) |=> in_pd)
		else $error("left power-down without release");
	lock_skip_a: assert property (
		(try_arr && protect_scheme_select_reg && prot_lk) |=> !array_go)
		else $error("locked region accepted");
	locks_set_a: assert property (
		$rose(rst_n) |-> &lock_reg)
		else $error("lock bits not set after reset");
	busy_flag_a: assert property (
		(arr_ok || is_stwr) |=> in_busy ##1 status_byte_one[0])
		else $error("busy flag missing");
	prot_reset_a: assert property (
		$rose(rst_n) |-> block_protect_bits_reg == 4'h0
			&& !top_bottom_select_reg && !complement_protect_reg)
		else $error("protect bits not zero after reset");
	pin_block_a: assert property (
		(try_stwr && status_protect_bit_reg && !wp_s
			&& !quad_enable_bit_reg) |=> !in_busy)
		else $error("status write passed low pin");
	st_lock_a: assert property (
		(try_stwr && status_lock_bit_reg) |=> !in_busy)
		else $error("status write passed lock");
	otp_hold_a: assert property (
		(try_stwr && otp_reg) |=> !in_busy)
		else $error("status write passed permanent lock");
	prot_drop_a: assert property (
		(try_arr && tgt_prot) |=> !array_go && !in_busy)
		else $error("protected operation started");

	stwr_c: cover property (is_stwr ##[1:300] op_done);
	arr_c: cover property (arr_ok ##1 array_go);
	pd_c: cover property (is_pd ##[1:1000] is_rpd);
	unlk_c: cover property (is_unlk);

endmodule

// ---- verification/sfw_host.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// spi host model, mode 0, one data bit per clock
// ------------------------------------------------------------
module sfw_host (
	// clock
	input  wire logic clk,
	// serial link
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// a deselected data line toggles so a stale bit never looks valid
	always @(posedge clk)
		if (spi_cs_n)
			spi_mosi <= ~spi_mosi;

	// sclk stands low outside frames; 8 clk per bit gives 400 ns
	task automatic frame(input logic [47:0] d, input int n,
		output logic [7:0] rd);
		rd = 8'h00;
		@(posedge clk);
		spi_cs_n <= 1'b0;
		for (int i = 0; i < 8 * n; i++) begin
			@(posedge clk);
			spi_mosi <= d[47-i];
			repeat (3) @(posedge clk);
			spi_sclk <= 1'b1;
			rd = {rd[6:0], spi_miso};
			repeat (4) @(posedge clk);
			spi_sclk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		spi_cs_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/100ps
module tb;
	logic        clk;
	logic        rst_n;
	logic        wp_n;
	logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
	logic        array_go;
	logic [7:0]  array_op, st1, st2, rd;
	logic [24:0] array_addr, a;
	logic [32:0] exp_q[$];
	int          mismatches = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int unsigned seed;
	// a released line shows the inverse so a stale bit is caught
	wire         miso_line = spi_miso_oe ? spi_miso : ~spi_miso;

	// short busy and delay counts keep the run brief
	sfw_top #(.WR_DELAY_CYC(100), .PROG_CYC(150), .ERASE_CYC(150),
		.STWR_CYC(100)) sfw_top_inst (.clk, .rst_n, .spi_sclk,
		.spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .wp_n,
		.array_go, .array_op, .array_addr, .status_byte_one(st1),
		.status_byte_two(st2));
	sfw_host sfw_host_inst (.clk, .spi_sclk, .spi_cs_n, .spi_mosi,
		.spi_miso(miso_line));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_st(input logic [7:0] got, input logic [7:0] exp);
		chk({25'h0, got}, {25'h0, exp});
	endtask
	task automatic cmp_go(input logic [32:0] got, input logic [32:0] exp);
		chk(got, exp);
	endtask
	task automatic cmp_oe(input logic got, input logic exp);
		chk({32'h0, got}, {32'h0, exp});
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// an unexpected request meets an empty queue and fails
	always @(posedge clk)
		if (array_go === 1'b1)
			cmp_go({array_op, array_addr},
				exp_q.size() > 0 ? exp_q.pop_front() : 33'h0);
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// host sequences
	// ------------------------------------------------------------
	task automatic send(input logic [47:0] d, input int n);
		sfw_host_inst.frame(d, n, rd);
	endtask
	task automatic wren();
		send({sfw_pkg::OP_WREN, 40'h0}, 1);
	endtask
	task automatic idle();
		for (int i = 0; i < 400 && st1[0] !== 1'b0; i++)
			@(posedge clk);
		@(posedge clk);
	endtask
	task automatic sw(input logic [7:0] op, input logic [7:0] v);
		wren();
		send({op, v, 32'h0}, 2);
		idle();
	endtask
	task automatic adr(input logic [7:0] op, input logic [24:0] ad,
		input bit acc);
		if (acc)
			exp_q.push_back({op, ad});
		send({op, 7'h0, ad, 8'h00}, 5);
	endtask

	initial begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		seed = $urandom(32'h8b652ad8);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		cmp_st(st1, 8'h00);
		cmp_st(st2, 8'h00);
		wren();
		cmp_st(st1, 8'h00);
		repeat (40) @(posedge clk);
		wren();
		cmp_st(st1, 8'h02);
		send({sfw_pkg::OP_WRDI, 40'h0}, 1);
		cmp_st(st1, 8'h00);
		a = 25'($urandom);
		send({sfw_pkg::OP_PP, 7'h0, a, 8'($urandom)}, 6);
		cmp_st(st1, 8'h00);
		wren();
		exp_q.push_back({sfw_pkg::OP_PP, a});
		send({sfw_pkg::OP_PP, 7'h0, a, 8'($urandom)}, 6);
		cmp_st(st1, 8'h03);
		wren();
		idle();
		cmp_st(st1, 8'h00);
		// range protection of the top block, then its complement
		sw(sfw_pkg::OP_WRSR1, 8'h04);
		fork
			send({sfw_pkg::OP_RDSR1, 40'h0}, 2);
			begin
				repeat (100) @(posedge clk);
				cmp_oe(spi_miso_oe, 1'b1);
			end
		join
		cmp_st(rd, 8'h04);
		cmp_oe(spi_miso_oe, 1'b0);
		wren();
		adr(sfw_pkg::OP_SE, 25'h1ff0000, 1'b0);
		cmp_st(st1, 8'h06);
		adr(sfw_pkg::OP_SE, 25'h0000000, 1'b1);
		idle();
		cmp_st(st1, 8'h04);
		wren();
		adr(sfw_pkg::OP_BE, 25'h0010000, 1'b1);
		send({sfw_pkg::OP_WRDI, 40'h0}, 1);
		cmp_st(st1, 8'h07);
		idle();
		cmp_st(st1, 8'h04);
		sw(sfw_pkg::OP_WRSR2, 8'h40);
		cmp_st(st2, 8'h40);
		send({sfw_pkg::OP_RDSR2, 40'h0}, 2);
		cmp_st(rd, 8'h40);
		wren();
		adr(sfw_pkg::OP_SE, 25'h0000000, 1'b0);
		cmp_st(st1, 8'h06);
		adr(sfw_pkg::OP_SE, 25'h1ff0000, 1'b1);
		idle();
		cmp_st(st1, 8'h04);
		// lock scheme: locked at power-on until unlocked
		sw(sfw_pkg::OP_WRSR3, 8'h04);
		send({sfw_pkg::OP_RDSR3, 40'h0}, 2);
		cmp_st(rd, 8'h04);
		wren();
		adr(sfw_pkg::OP_SE, 25'h0050000, 1'b0);
		cmp_st(st1, 8'h06);
		send({sfw_pkg::OP_CE, 40'h0}, 1);
		cmp_st(st1, 8'h06);
		adr(sfw_pkg::OP_UNLK, 25'h0050000, 1'b0);
		adr(sfw_pkg::OP_SE, 25'h0050000, 1'b1);
		idle();
		cmp_st(st1, 8'h04);
		sw(sfw_pkg::OP_WRSR3, 8'h00);
		// status protect bit against the pin
		sw(sfw_pkg::OP_WRSR1, 8'h80);
		wp_n <= 1'b0;
		wren();
		send({sfw_pkg::OP_WRSR1, 40'h0}, 2);
		cmp_st(st1, 8'h82);
		wp_n <= 1'b1;
		send({sfw_pkg::OP_WRSR1, 40'h0}, 2);
		idle();
		cmp_st(st1, 8'h00);
		sw(sfw_pkg::OP_WRSR1, 8'h80);
		sw(sfw_pkg::OP_WRSR2, 8'h42);
		wp_n <= 1'b0;
		sw(sfw_pkg::OP_WRSR1, 8'h04);
		cmp_st(st1, 8'h04);
		sw(sfw_pkg::OP_WRSR1, 8'h08);
		cmp_st(st1, 8'h08);
		// power-down ignores all but release
		send({sfw_pkg::OP_PD, 40'h0}, 1);
		wren();
		cmp_st(st1, 8'h08);
		send({sfw_pkg::OP_RPD, 40'h0}, 1);
		wren();
		cmp_st(st1, 8'h0a);
		// status lock holds until a power cycle
		sw(sfw_pkg::OP_WRSR2, 8'h01);
		cmp_st(st2, 8'h01);
		sw(sfw_pkg::OP_WRSR2, 8'h00);
		cmp_st(st2, 8'h01);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		cmp_st(st2, 8'h00);
		cmp_st(st1, 8'h00);
		// prefix pair, then a three-byte write that sets the lock bit
		send({sfw_pkg::OP_PFX1, 40'h0}, 1);
		send({sfw_pkg::OP_PFX2, 40'h0}, 1);
		wren();
		send({sfw_pkg::OP_WRSR1, 8'h00, 8'h01, 24'h0}, 3);
		idle();
		cmp_st(st2, 8'h01);
		sw(sfw_pkg::OP_WRSR2, 8'h00);
		cmp_st(st2, 8'h01);
		cmp_go(33'(exp_q.size()), 33'h0);
		summarize();
	end
endmodule
